// ---- hw/usb_ep0_out_defines.vh ----
// Function
// - register at 0x0B00, resets to 0x00008000
// - enable bit 31: software sets, core clears
// - disable bit 30 reads zero, writes ignored
// - writing one to bit 27 sets NAK
// - writing one to bit 26 clears NAK
// - stall bit 21 answers OUT with STALL
// - SETUP clears stall; software only sets
// - stall wins over NAK status
// - snoop bit 20 skips data CRC check
// - type field 19:18 fixed at 00
// - all clear: answer follows receive FIFO state
// - NAK status 17 set: NAK every OUT
// - active bit 15 always reads one
// - size field 1:0 mirrors IN endpoint 0
`ifndef USB_EP0_OUT_DEFINES_VH
`define USB_EP0_OUT_DEFINES_VH
`define EP0_OUT_CTL_ADDR 12'hB00
`define EP0_OUT_CTL_RESET 32'h00008000
`define BIT_ENABLE 31
`define BIT_DISABLE 30
`define BIT_SET_NAK 27
`define BIT_CLR_NAK 26
`define BIT_STALL 21
`define BIT_SNOOP 20
`define BIT_NAK_STATUS 17
`define BIT_ACTIVE 15
`define BIT_TYPE_HI 19
`define BIT_TYPE_LO 18
`define BIT_MPS_HI 1
`define BIT_MPS_LO 0
`define EP_TYPE_CONTROL 2'h0
`define HS_NONE 2'h0
`define HS_NAK 2'h1
`define HS_STALL 2'h2
`define HS_FIFO 2'h3
`endif

// ---- hw/ep0_out_answer.v ----
`include "usb_ep0_out_defines.vh"
module ep0_out_answer (
    // state
    input wire stall,
    input wire nak_status,
    input wire global_out_nak_bit,
    // decision
    output reg [1:0] answer
);
    always @* begin
        if (stall)
            answer = `HS_STALL;
        else if (global_out_nak_bit)
            answer = `HS_NAK;
        else if (nak_status)
            answer = `HS_NAK;
        else
            answer = `HS_FIFO;
    end
endmodule // ep0_out_answer

// ---- hw/usb_out_ep0_control.v ----
`include "usb_ep0_out_defines.vh"
module usb_out_ep0_control (
    // clock and reset
    input wire mclk,
    input wire rst_n,
    // avalon-mm slave
    input wire [11:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    // core side
    input wire global_out_nak_bit,
    input wire [1:0] in_ep0_max_packet_size,
    input wire setup_received,
    input wire core_disable_endpoint,
    output reg endpoint_enable_bit,
    output reg stall_out,
    output reg nak_out,
    output reg snoop_out,
    output reg [1:0] out_answer,
    output reg [1:0] max_packet_size_field
);
    // handshake states, one-hot
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_ANSWER = 2'b10;

    // stored state
    reg enable;
    reg stall;
    reg snoop;
    reg nak_status;
    reg [1:0] mps;
    reg [1:0] state;
    // next values
    reg next_enable;
    reg next_stall;
    reg next_snoop;
    reg next_nak_status;
    reg [1:0] next_state;
    reg [31:0] next_readdata;
    reg [31:0] image;
    wire [1:0] next_answer;
    // write decode
    wire [31:0] bit_written;
    wire hit;
    wire request;
    wire accept;
    wire wr;
    wire rd;
    wire snoop_lane;

    // byte lane that carries bit pos of the data word
    function lane_on;
        input [3:0] lanes;
        input integer pos;
        begin
            lane_on = lanes[pos / 8];
        end
    endfunction

    assign hit = (avs_address == `EP0_OUT_CTL_ADDR);
    assign request = avs_read || avs_write;
    // taken only from idle, so a held request is taken again every other cycle
    assign accept = request && (state == ST_IDLE);
    assign wr = avs_write && accept && hit;
    assign rd = avs_read && accept;
    assign snoop_lane = wr && lane_on(avs_byteenable, `BIT_SNOOP);

    // a written one per bit; unmapped writes never reach the register
    genvar i;
    generate
        for (i = 0; i < 32; i = i + 1) begin : g_written
            assign bit_written[i] = wr && lane_on(avs_byteenable, i) && avs_writedata[i];
        end
    endgenerate

    ep0_out_answer u_answer (
        .stall(stall),
        .nak_status(nak_status),
        .global_out_nak_bit(global_out_nak_bit),
        .answer(next_answer)
    );

    // one wait state: the answer cycle always follows the taking cycle
    always @* begin
        case (state)
            ST_IDLE: begin
                if (request) begin
                    next_state = ST_ANSWER;
                end else begin
                    next_state = ST_IDLE;
                end
            end
            ST_ANSWER: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge mclk) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            avs_waitrequest <= 1'b1;
        end else begin
            state <= next_state;
            avs_waitrequest <= !accept;
        end
    end

    // read image: fixed fields are forced here and never stored
    always @* begin
        image = `EP0_OUT_CTL_RESET;
        image[`BIT_ENABLE] = enable;
        image[`BIT_DISABLE] = 1'b0;
        image[`BIT_SET_NAK] = 1'b0;
        image[`BIT_CLR_NAK] = 1'b0;
        image[`BIT_STALL] = stall;
        image[`BIT_SNOOP] = snoop;
        image[`BIT_TYPE_HI:`BIT_TYPE_LO] = `EP_TYPE_CONTROL;
        image[`BIT_NAK_STATUS] = nak_status;
        image[`BIT_ACTIVE] = 1'b1;
        image[`BIT_MPS_HI:`BIT_MPS_LO] = mps;
    end

    always @* begin
        if (hit) begin
            next_readdata = image;
        end else begin
            next_readdata = 32'h00000000;
        end
    end

    // read data stands until the next read
    always @(posedge mclk) begin
        if (!rst_n) begin
            avs_readdata <= 32'h00000000;
        end else if (rd) begin
            avs_readdata <= next_readdata;
        end
    end

    // software set beats the core's clear landing in the same cycle
    always @* begin
        next_enable = enable;
        if (bit_written[`BIT_ENABLE]) begin
            next_enable = 1'b1;
        end else if (core_disable_endpoint) begin
            next_enable = 1'b0;
        end
    end

    // a SETUP is the only way out of stall, so it wins over a set
    always @* begin
        next_stall = stall;
        if (setup_received) begin
            next_stall = 1'b0;
        end else if (bit_written[`BIT_STALL]) begin
            next_stall = 1'b1;
        end
    end

    always @* begin
        next_snoop = snoop;
        if (snoop_lane) begin
            next_snoop = avs_writedata[`BIT_SNOOP];
        end
    end

    // set beats clear when software writes both commands
    always @* begin
        next_nak_status = nak_status;
        if (bit_written[`BIT_SET_NAK]) begin
            next_nak_status = 1'b1;
        end else if (bit_written[`BIT_CLR_NAK]) begin
            next_nak_status = 1'b0;
        end
    end

    always @(posedge mclk) begin
        if (!rst_n) begin
            enable <= 1'b0;
        end else begin
            enable <= next_enable;
        end
    end

    always @(posedge mclk) begin
        if (!rst_n) begin
            stall <= 1'b0;
        end else begin
            stall <= next_stall;
        end
    end

    always @(posedge mclk) begin
        if (!rst_n) begin
            snoop <= 1'b0;
        end else begin
            snoop <= next_snoop;
        end
    end

    always @(posedge mclk) begin
        if (!rst_n) begin
            nak_status <= 1'b0;
        end else begin
            nak_status <= next_nak_status;
        end
    end

    always @(posedge mclk) begin
        if (!rst_n) begin
            mps <= 2'h0;
        end else begin
            mps <= in_ep0_max_packet_size;
        end
    end

    // outputs come straight from flops, one cycle behind the state
    always @(posedge mclk) begin
        if (!rst_n) begin
            endpoint_enable_bit <= 1'b0;
        end else begin
            endpoint_enable_bit <= enable;
        end
    end

    always @(posedge mclk) begin
        if (!rst_n) begin
            stall_out <= 1'b0;
        end else begin
            stall_out <= stall;
        end
    end

    always @(posedge mclk) begin
        if (!rst_n) begin
            nak_out <= 1'b0;
        end else begin
            nak_out <= nak_status;
        end
    end

    always @(posedge mclk) begin
        if (!rst_n) begin
            snoop_out <= 1'b0;
        end else begin
            snoop_out <= snoop;
        end
    end

    always @(posedge mclk) begin
        if (!rst_n) begin
            out_answer <= `HS_FIFO;
        end else begin
            out_answer <= next_answer;
        end
    end

    always @(posedge mclk) begin
        if (!rst_n) begin
            max_packet_size_field <= 2'h0;
        end else begin
            max_packet_size_field <= mps;
        end
    end
endmodule // usb_out_ep0_control

// ---- tb/usb_out_ep0_control_assertions.sv ----
module usb_out_ep0_control_assertions (
    input wire mclk, rst_n, avs_read, avs_write, avs_waitrequest, global_out_nak_bit, setup_received,
    input wire core_disable_endpoint, endpoint_enable_bit, stall_out, nak_out,
    input wire [11:0] avs_address,
    input wire [31:0] avs_readdata,
    input wire [1:0] in_ep0_max_packet_size, max_packet_size_field, out_answer
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // two samples so a lag of one stage between copies is tolerated
    sequence s_stall; stall_out[*2]; endsequence
    property p_stall; s_stall |-> out_answer == 2'h2; endproperty
    a_stall: assert property (p_stall) else $error("stall not answered");
    property p_nak; (!stall_out && !global_out_nak_bit && nak_out)[*2] |-> out_answer == 2'h1; endproperty
    a_nak: assert property (p_nak) else $error("nak not answered");
    property p_fifo; (!stall_out && !global_out_nak_bit && !nak_out)[*2] |-> out_answer == 2'h3; endproperty
    a_fifo: assert property (p_fifo) else $error("fifo answer missing");
    property p_setup; setup_received |-> ##2 !stall_out; endproperty
    a_setup: assert property (p_setup) else $error("setup left stall");
    property p_dis; core_disable_endpoint && !avs_write |-> ##2 !endpoint_enable_bit; endproperty
    a_dis: assert property (p_dis) else $error("enable not cleared");
    property p_mps; (rst_n && $stable(in_ep0_max_packet_size))[*3] |-> max_packet_size_field == in_ep0_max_packet_size;
    endproperty
    a_mps: assert property (p_mps) else $error("size not mirrored");
    property p_ro; !avs_waitrequest && $past(avs_read) && $past(avs_address) == 12'hB00 |-> !avs_readdata[30] &&
        avs_readdata[15] && avs_readdata[19:18] == 2'h0 && avs_readdata[27:26] == 2'h0; endproperty
    a_ro: assert property (p_ro) else $error("fixed bits wrong");
    property p_wait; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
    a_wait: assert property (p_wait) else $error("no answer");
endmodule // usb_out_ep0_control_assertions
bind usb_out_ep0_control usb_out_ep0_control_assertions usb_out_ep0_control_assertions_i (.*);

// ---- tb/usb_host_model.sv ----
module usb_host_model (input wire mclk, input wire send_setup, output logic setup_received = 1'b0);
    timeunit 1ns;
    timeprecision 1ps;
    // no single token per request: a held request gives a pulse every other cycle
    always @(posedge mclk) setup_received <= send_setup && !setup_received;
endmodule // usb_host_model

// ---- tb/usb_out_ep0_control_test.sv ----
module usb_out_ep0_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 0, rst_n = 0, avs_read = 0, avs_write = 0, global_out_nak_bit = 0, send_setup = 0;
    logic core_disable_endpoint = 0, setup_received, avs_waitrequest, endpoint_enable_bit, stall_out, nak_out, snoop_out;
    logic [11:0] avs_address = 0;
    logic [31:0] avs_writedata = 0, avs_readdata, rd;
    logic [3:0] avs_byteenable = 4'hF;
    logic [1:0] in_ep0_max_packet_size = 2'h3, out_answer, max_packet_size_field;
    int error_cnt = 0, checks = 0, cyc = 0;
    always #2 mclk = ~mclk;
    usb_host_model usb_host_model_i (.*);
    usb_out_ep0_control usb_out_ep0_control_i (.*);
    task complete_run;
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input logic [31:0] g, e);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %0t got %h exp %h", $time, g, e);
        end
    endtask
    task acc(input logic w, input logic [11:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do @(posedge mclk); while (avs_waitrequest);
        rd = avs_readdata;
        avs_write <= 0;
        avs_read <= 0;
        @(posedge mclk);
    endtask
    task step(input logic [31:0] d, e, input logic [5:0] o);
        acc(1, 12'hB00, d);
        acc(0, 12'hB00, 0);
        chk(rd, e);
        repeat (2) @(posedge mclk);
        chk({endpoint_enable_bit, stall_out, nak_out, snoop_out, out_answer}, o);
    endtask
    always @(posedge mclk) if (++cyc > 1000) begin
        error_cnt++;
        complete_run;
    end
    initial begin
        repeat (2) @(posedge mclk);
        rst_n <= 1;
        @(posedge mclk);
        acc(0, 12'hB00, 0);
        chk(rd, 32'h00008003);
        chk(max_packet_size_field, 32'h3);
        step(32'h8C300000, 32'h80328003, 6'h3E);
        step(0, 32'h80228003, 6'h3A);
        send_setup <= 1;
        @(posedge mclk);
        send_setup <= 0;
        step(0, 32'h80028003, 6'h29);
        step(32'h04000000, 32'h80008003, 6'h23);
        global_out_nak_bit <= 1;
        step(0, 32'h80008003, 6'h21);
        core_disable_endpoint <= 1;
        in_ep0_max_packet_size <= 2'h0;
        @(posedge mclk);
        core_disable_endpoint <= 0;
        step(0, 32'h00008000, 6'h01);
        acc(0, 12'h004, 0);
        chk(rd, 0);
        chk(max_packet_size_field, 0);
        complete_run;
    end
endmodule // usb_out_ep0_control_test
